// ---- rtl/bkr_regs.sv ----
// Purpose: Buck one control registers with Avalon-MM slave and output control.
// Assumes: OTP defaults are stable, same-clock inputs; state pins are asynchronous.
// Notes: One wait state on every access; unmapped words read zero.
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
module bkr_regs (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [bkr_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [bkr_pkg::DATA_W-1:0] avs_writedata,
  output logic [bkr_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [bkr_pkg::VOLT_W-1:0] otp_normal_voltage,
  input wire logic [bkr_pkg::VOLT_W-1:0] otp_standby_voltage,
  input wire logic [bkr_pkg::VOLT_W-1:0] otp_sleep_voltage,
  input wire logic [bkr_pkg::SWMODE_W-1:0] otp_switch_mode,
  input wire logic otp_ramp_speed,
  input wire logic [1:0] otp_switching_freq,
  input wire logic otp_current_limit,
  input wire logic standby_pin,
  input wire logic sleep_pin,
  input wire logic turn_off_pin,
  output logic buck_enable,
  output logic buck_sleep,
  output logic [bkr_pkg::VOLT_W-1:0] vout_code,
  output logic ramp_busy,
  output logic [bkr_pkg::SWMODE_W-1:0] switch_mode,
  output logic [1:0] phase_clock_select,
  output logic [1:0] switching_freq_select,
  output logic current_limit_select
);
  import bkr_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [VOLT_W-1:0] normal_q, normal_d;
  logic [VOLT_W-1:0] standby_q, standby_d;
  logic [VOLT_W-1:0] sleep_q, sleep_d;
  logic [SWMODE_W-1:0] swmode_q, swmode_d;
  logic offb_q, offb_d;
  logic ramp_q, ramp_d;
  logic [1:0] phase_q, phase_d;
  logic [1:0] freq_q, freq_d;
  logic ilim_q, ilim_d;
  logic wait_q, wait_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic [DATA_W-1:0] rmux;
  logic [5:0] idx;
  logic aligned;
  logic take;
  logic wr_en;
  logic [7:0] wb;
  logic [2:0] pins_s;
  bkr_ops_t ops;
  bkr_reg_t st_q, st_d;
  logic en_q, en_d;
  logic slp_q, slp_d;
  logic [VOLT_W-1:0] target;

  assign idx = avs_address[ADDR_W-1:2];
  assign aligned = (avs_address[1:0] == WORD_ALIGN);
  // An access completes at the edge where the slave shows waitrequest low
  assign take = (avs_read | avs_write) & ~wait_q;
  assign wr_en = take & avs_write & avs_byteenable[0] & aligned;
  assign wb = avs_writedata[7:0];

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  always_comb
  begin
    // Exactly one wait state, then back to waiting for the next request
    wait_d = ~((avs_read | avs_write) & wait_q);
    rmux = '0;
    if (aligned)
    begin
      unique case (idx)
        IDX_NORMAL: rmux[VOLT_LSB +: VOLT_W] = normal_q;
        IDX_STANDBY: rmux[VOLT_LSB +: VOLT_W] = standby_q;
        IDX_SLEEP: rmux[VOLT_LSB +: VOLT_W] = sleep_q;
        IDX_MODE:
        begin
          rmux[SWMODE_LSB +: SWMODE_W] = swmode_q;
          rmux[OFFB_BIT] = offb_q;
        end
        IDX_CONFIG, IDX_CONFIG_ALIAS:
        begin
          rmux[RAMP_BIT] = ramp_q;
          rmux[PHASE_LSB +: 2] = phase_q;
          rmux[FREQ_LSB +: 2] = freq_q;
          rmux[ILIM_BIT] = ilim_q;
        end
        default: rmux = '0;
      endcase
    end
    rdata_d = (avs_read & wait_q) ? rmux : rdata_q;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      wait_q <= 1'b1;
      rdata_q <= '0;
    end
    else
    begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_comb
  begin
    normal_d = normal_q;
    standby_d = standby_q;
    sleep_d = sleep_q;
    swmode_d = swmode_q;
    offb_d = offb_q;
    ramp_d = ramp_q;
    phase_d = phase_q;
    freq_d = freq_q;
    ilim_d = ilim_q;
    if (wr_en)
    begin
      unique case (idx)
        IDX_NORMAL: normal_d = wb[VOLT_LSB +: VOLT_W];
        IDX_STANDBY: standby_d = wb[VOLT_LSB +: VOLT_W];
        IDX_SLEEP: sleep_d = wb[VOLT_LSB +: VOLT_W];
        IDX_MODE:
        begin
          swmode_d = wb[SWMODE_LSB +: SWMODE_W];
          offb_d = wb[OFFB_BIT];
        end
        IDX_CONFIG, IDX_CONFIG_ALIAS:
        begin
          ramp_d = wb[RAMP_BIT];
          phase_d = wb[PHASE_LSB +: 2];
          freq_d = wb[FREQ_LSB +: 2];
          ilim_d = wb[ILIM_BIT];
        end
        default: normal_d = normal_q;
      endcase
    end
  end

  // Reset is synchronous, so loading port values here is safe
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      normal_q <= otp_normal_voltage;
      standby_q <= otp_standby_voltage;
      sleep_q <= otp_sleep_voltage;
      swmode_q <= otp_switch_mode;
      offb_q <= 1'b0;
      ramp_q <= otp_ramp_speed;
      phase_q <= 2'h0;
      freq_q <= otp_switching_freq;
      ilim_q <= otp_current_limit;
    end
    else
    begin
      normal_q <= normal_d;
      standby_q <= standby_d;
      sleep_q <= sleep_d;
      swmode_q <= swmode_d;
      offb_q <= offb_d;
      ramp_q <= ramp_d;
      phase_q <= phase_d;
      freq_q <= freq_d;
      ilim_q <= ilim_d;
    end
  end

  // ----------------------------------------
  // Operating state
  // ----------------------------------------
  bkr_sync #(
    .W(3)
  ) u_sync (
    .mclk(mclk),
    .srst(srst),
    .async_in({turn_off_pin, sleep_pin, standby_pin}),
    .sync_out(pins_s)
  );

  always_comb
  begin
    if (pins_s[1])
      ops = OPS_SLEEP;
    else if (pins_s[0])
      ops = OPS_STANDBY;
    else
      ops = OPS_NORMAL;
    // Turn-off outranks the sleep and standby pins
    if (pins_s[2])
      st_d = offb_q ? REG_SLEEP : REG_OFF;
    else if (ops == OPS_SLEEP)
      st_d = REG_SLEEP;
    else
      st_d = REG_ON;
    // Registered from the next state so the pins move with st_q
    en_d = (st_d != REG_OFF);
    slp_d = (st_d == REG_SLEEP);
    unique case (st_q)
      REG_SLEEP: target = sleep_q;
      REG_ON: target = (ops == OPS_STANDBY) ? standby_q : normal_q;
      REG_OFF: target = normal_q;
      default: target = normal_q;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      st_q <= REG_ON;
      en_q <= 1'b1;
      slp_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      en_q <= en_d;
      slp_q <= slp_d;
    end
  end

  bkr_ramp u_ramp (
    .mclk(mclk),
    .srst(srst),
    .init_code(otp_normal_voltage),
    .target(target),
    .slow(ramp_q),
    .code(vout_code),
    .busy(ramp_busy)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign buck_enable = en_q;
  assign buck_sleep = slp_q;
  assign switch_mode = swmode_q;
  assign phase_clock_select = phase_q;
  assign switching_freq_select = freq_q;
  assign current_limit_select = ilim_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  normal_write_a: assert property (
    wr_en && idx == IDX_NORMAL |=> normal_q == $past(wb[VOLT_LSB +: VOLT_W]))
    else $error("normal voltage write lost");
  standby_write_a: assert property (
    wr_en && idx == IDX_STANDBY |=> standby_q == $past(wb[VOLT_LSB +: VOLT_W]))
    else $error("standby voltage write lost");
  sleep_rdback_a: assert property (
    avs_read && wait_q && aligned && idx == IDX_SLEEP
      |=> !wait_q && avs_readdata == DATA_W'(sleep_q))
    else $error("sleep voltage readback wrong");
  off_behaviour_a: assert property (
    pins_s[2] && !offb_q |=> !buck_enable)
    else $error("turn-off did not switch off");
  off_to_sleep_a: assert property (
    pins_s[2] && offb_q |=> buck_enable && buck_sleep)
    else $error("turn-off did not enter sleep");
  mode_out_a: assert property (
    wr_en && idx == IDX_MODE |=> switch_mode == $past(wb[SWMODE_LSB +: SWMODE_W]))
    else $error("switching mode not applied");
  ramp_pace_a: assert property (
    $changed(vout_code) && ramp_q && $past(ramp_q) |=> $stable(vout_code)[*8])
    else $error("slow ramp stepped too fast");
  alias_cfg_a: assert property (
    wr_en && idx == IDX_CONFIG_ALIAS
      |=> phase_clock_select == $past(wb[PHASE_LSB +: 2])
        && switching_freq_select == $past(wb[FREQ_LSB +: 2]))
    else $error("config alias write lost");
  ilim_out_a: assert property (
    wr_en && idx == IDX_CONFIG |=> current_limit_select == $past(wb[ILIM_BIT]))
    else $error("current limit not applied");
  reserved_zero_a: assert property (
    !wait_q |-> avs_readdata[DATA_W-1:RAMP_BIT+1] == '0)
    else $error("reserved bits read nonzero");
  one_wait_a: assert property (
    (avs_read || avs_write) && wait_q |=> !wait_q ##1 wait_q)
    else $error("access not answered after one wait state");
  ramp_reach_a: assert property (
    ramp_busy && !ramp_q |-> ##[1:820] ($changed(vout_code) || !ramp_busy))
    else $error("ramp made no progress");

  standby_cov: cover property (buck_enable && !buck_sleep && pins_s[0] && !ramp_busy);
  sleep_off_cov: cover property (pins_s[2] && offb_q ##1 buck_sleep);
  alias_rd_cov: cover property (avs_read && !wait_q && idx == IDX_CONFIG_ALIAS);
endmodule : bkr_regs

// ---- rtl/bkr_pkg.sv ----
// Purpose: Shared constants for the buck one control register bank.
// Assumes: Avalon-MM byte addressing, one register per aligned 32-bit word.
// Notes: Register index times four is the byte address.
package bkr_pkg;
  // ----------------------------------------
  // Register map (indices)
  // ----------------------------------------
  localparam logic [5:0] IDX_NORMAL = 6'h20;
  localparam logic [5:0] IDX_STANDBY = 6'h21;
  localparam logic [5:0] IDX_SLEEP = 6'h22;
  localparam logic [5:0] IDX_MODE = 6'h23;
  localparam logic [5:0] IDX_CONFIG = 6'h24;
  localparam logic [5:0] IDX_CONFIG_ALIAS = 6'h32;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int VOLT_W = 5;
  localparam int SWMODE_W = 4;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int VOLT_LSB = 0;
  localparam int SWMODE_LSB = 0;
  localparam int OFFB_BIT = 5;
  localparam int RAMP_BIT = 6;
  localparam int PHASE_LSB = 4;
  localparam int FREQ_LSB = 2;
  localparam int ILIM_BIT = 0;
  localparam logic [1:0] WORD_ALIGN = 2'h0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int RAMP_FAST_PS = 2000000;
  localparam int RAMP_SLOW_PS = 4000000;
  localparam int RAMP_CNT_W = 10;
  localparam logic [RAMP_CNT_W-1:0] RAMP_FAST_CYC =
    RAMP_CNT_W'(RAMP_FAST_PS / CLK_PERIOD_PS);
  localparam logic [RAMP_CNT_W-1:0] RAMP_SLOW_CYC =
    RAMP_CNT_W'(RAMP_SLOW_PS / CLK_PERIOD_PS);

  // ----------------------------------------
  // States
  // ----------------------------------------
  typedef enum logic [1:0] {
    OPS_NORMAL = 2'b00,
    OPS_STANDBY = 2'b01,
    OPS_SLEEP = 2'b10
  } bkr_ops_t;

  typedef enum logic [1:0] {
    REG_ON = 2'b00,
    REG_SLEEP = 2'b01,
    REG_OFF = 2'b10
  } bkr_reg_t;
endpackage : bkr_pkg

// ---- rtl/bkr_sync.sv ----
// Purpose: Two flip-flop synchroniser for pin inputs.
// Assumes: Bits are independent levels.
// Notes: Only the second stage may be read.
`timescale 1ns/1ps
module bkr_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  import bkr_pkg::*;
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule : bkr_sync

// ---- rtl/bkr_ramp.sv ----
// Purpose: Steps the applied voltage code one step per ramp period.
// Assumes: One code step equals one 25 mV step.
// Notes: A new target is followed from the current code, not restarted.
`timescale 1ns/1ps
module bkr_ramp (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [bkr_pkg::VOLT_W-1:0] init_code,
  input wire logic [bkr_pkg::VOLT_W-1:0] target,
  input wire logic slow,
  output logic [bkr_pkg::VOLT_W-1:0] code,
  output logic busy
);
  import bkr_pkg::*;
  logic [VOLT_W-1:0] code_q;
  logic [VOLT_W-1:0] code_d;
  logic [RAMP_CNT_W-1:0] cnt_q;
  logic [RAMP_CNT_W-1:0] cnt_d;
  logic busy_q;
  logic busy_d;
  logic [RAMP_CNT_W-1:0] period;

  always_comb
  begin
    period = slow ? RAMP_SLOW_CYC : RAMP_FAST_CYC;
    code_d = code_q;
    cnt_d = cnt_q;
    if (code_q == target)
      cnt_d = '0;
    else if (cnt_q >= period - RAMP_CNT_W'(1))
    begin
      // Step period elapsed: one step toward the target
      cnt_d = '0;
      code_d = (target > code_q) ? code_q + VOLT_W'(1) : code_q - VOLT_W'(1);
    end
    else
      cnt_d = cnt_q + RAMP_CNT_W'(1);
    busy_d = (code_d != target);
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      code_q <= init_code;
      cnt_q <= '0;
      busy_q <= 1'b0;
    end
    else
    begin
      code_q <= code_d;
      cnt_q <= cnt_d;
      busy_q <= busy_d;
    end
  end

  assign code = code_q;
  assign busy = busy_q;
endmodule : bkr_ramp

// ---- dv/bkr_regs_test.sv ----
// Purpose: Self-checking bench for the buck one control register bank.
// Assumes: One wait state per access; pin levels settle within a few cycles.
// Notes: Expected values are built from the field layout, never read back from outputs.
`timescale 1ns/1ps
module bkr_regs_test;
  import bkr_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic standby_pin = 1'b0;
  logic sleep_pin = 1'b0;
  logic turn_off_pin = 1'b0;
  logic [4:0] otp_normal = 5'h0c;
  logic [3:0] otp_mode = 4'h5;
  logic buck_enable;
  logic buck_sleep;
  logic [4:0] vout_code;
  logic ramp_busy;
  logic [3:0] switch_mode;
  logic [1:0] phase_clock_select;
  logic [1:0] switching_freq_select;
  logic current_limit_select;
  logic [31:0] rd;
  int num_errors = 0;
  int comparisons = 0;
  logic [7:0] addrs [5] = '{8'h80, 8'h84, 8'h88, 8'h8c, 8'h90};
  logic [7:0] masks [5] = '{8'h1f, 8'h1f, 8'h1f, 8'h2f, 8'h7d};

  always #2.5 mclk = ~mclk;

  bkr_regs uut (.mclk(mclk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .otp_normal_voltage(otp_normal), .otp_standby_voltage(5'h08), .otp_sleep_voltage(5'h04),
    .otp_switch_mode(otp_mode), .otp_ramp_speed(1'b0), .otp_switching_freq(2'h2),
    .otp_current_limit(1'b1), .standby_pin(standby_pin), .sleep_pin(sleep_pin),
    .turn_off_pin(turn_off_pin), .buck_enable(buck_enable), .buck_sleep(buck_sleep),
    .vout_code(vout_code), .ramp_busy(ramp_busy), .switch_mode(switch_mode),
    .phase_clock_select(phase_clock_select), .switching_freq_select(switching_freq_select),
    .current_limit_select(current_limit_select));

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic tally_and_finish;
    if (num_errors == 0 && comparisons > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Request is held until the edge that samples waitrequest low
  task automatic av_xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= ~wr;
    // A slave that never answers is ended by the watchdog
    do
    begin
      @(posedge mclk);
    end
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : av_xfer

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
    av_xfer(1'b0, a, 8'h00);
    chk(name, {24'h0, exp}, rd);
  endtask : rd_chk

  task automatic do_reset;
    @(posedge mclk);
    srst <= 1'b1;
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
  endtask : do_reset

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : wait_cyc

  // ----------------------------------------
  // Watchdog: the tests need about 3000 cycles
  // ----------------------------------------
  initial
  begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    wait_cyc(10);
    srst <= 1'b0;
    wait_cyc(2);
    rd_chk("normal_rst", 8'h80, 8'h0c);
    rd_chk("standby_rst", 8'h84, 8'h08);
    rd_chk("sleep_rst", 8'h88, 8'h04);
    rd_chk("mode_rst", 8'h8c, 8'h05);
    rd_chk("config_rst", 8'h90, 8'h09);
    chk("vout_rst", 32'h0c, {27'h0, vout_code});
    chk("ilim_rst", 32'h1, {31'h0, current_limit_select});
    chk("freq_rst", 32'h2, {30'h0, switching_freq_select});
    // Every register takes all ones then all zeros; reserved bits must stay 0
    for (int i = 0; i < 5; i++)
    begin
      av_xfer(1'b1, addrs[i], 8'hff);
      rd_chk("reg_ones", addrs[i], masks[i]);
      av_xfer(1'b1, addrs[i], 8'h00);
      rd_chk("reg_zeros", addrs[i], 8'h00);
    end
    av_xfer(1'b1, 8'h90, 8'h55);
    rd_chk("alias_rd", 8'hc8, 8'h55);
    av_xfer(1'b1, 8'hc8, 8'h3c);
    rd_chk("alias_wr", 8'h90, 8'h3c);
    chk("phase_out", 32'h3, {30'h0, phase_clock_select});
    chk("freq_out", 32'h3, {30'h0, switching_freq_select});
    chk("ilim_out", 32'h0, {31'h0, current_limit_select});
    av_xfer(1'b1, 8'h8c, 8'h2a);
    rd_chk("mode_wr", 8'h8c, 8'h2a);
    chk("swmode_out", 32'ha, {28'h0, switch_mode});
    rd_chk("unmapped", 8'hc0, 8'h00);
    av_xfer(1'b1, 8'h81, 8'h1f);
    rd_chk("misaligned", 8'h81, 8'h00);
    rd_chk("misaligned_wr", 8'h80, 8'h00);
    @(posedge mclk);
    avs_byteenable <= 4'he;
    av_xfer(1'b1, 8'h80, 8'h1f);
    avs_byteenable <= 4'hf;
    rd_chk("be_off_wr", 8'h80, 8'h00);
    // ----------------------------------------
    // Ramp rate and state voltage selection
    // ----------------------------------------
    do_reset();
    wait_cyc(2);
    av_xfer(1'b1, 8'h80, 8'h0e);
    wait_cyc(3);
    chk("busy_ramp", 32'h1, {31'h0, ramp_busy});
    wait_cyc(850);
    chk("vout_fast", 32'h0e, {27'h0, vout_code});
    chk("busy_done", 32'h0, {31'h0, ramp_busy});
    av_xfer(1'b1, 8'h90, 8'h49);
    av_xfer(1'b1, 8'h80, 8'h0d);
    wait_cyc(600);
    chk("vout_slow_hold", 32'h0e, {27'h0, vout_code});
    wait_cyc(300);
    chk("vout_slow", 32'h0d, {27'h0, vout_code});
    av_xfer(1'b1, 8'h90, 8'h09);
    av_xfer(1'b1, 8'h84, 8'h0c);
    @(posedge mclk);
    standby_pin <= 1'b1;
    wait_cyc(500);
    chk("vout_standby", 32'h0c, {27'h0, vout_code});
    standby_pin <= 1'b0;
    // ----------------------------------------
    // Turn-off behaviour
    // ----------------------------------------
    turn_off_pin <= 1'b1;
    wait_cyc(6);
    chk("off_enable", 32'h0, {31'h0, buck_enable});
    chk("off_sleep", 32'h0, {31'h0, buck_sleep});
    turn_off_pin <= 1'b0;
    // New defaults must be picked up by the next reset
    otp_normal <= 5'h0a;
    otp_mode <= 4'h3;
    do_reset();
    wait_cyc(2);
    chk("vout_rerst", 32'h0a, {27'h0, vout_code});
    rd_chk("mode_rerst", 8'h8c, 8'h03);
    rd_chk("normal_rerst", 8'h80, 8'h0a);
    chk("enable_rerst", 32'h1, {31'h0, buck_enable});
    @(posedge mclk);
    sleep_pin <= 1'b1;
    wait_cyc(6);
    chk("sleep_pin", 32'h1, {31'h0, buck_sleep});
    sleep_pin <= 1'b0;
    av_xfer(1'b1, 8'h88, 8'h0b);
    av_xfer(1'b1, 8'h8c, 8'h25);
    @(posedge mclk);
    turn_off_pin <= 1'b1;
    wait_cyc(6);
    chk("offb_sleep", 32'h1, {31'h0, buck_sleep});
    chk("offb_enable", 32'h1, {31'h0, buck_enable});
    wait_cyc(500);
    chk("vout_sleep", 32'h0b, {27'h0, vout_code});
    tally_and_finish();
  end
endmodule : bkr_regs_test
